/* File: icc_pkg.sv */
// Purpose: Shared constants and types for the input capture channel.
// Assumes: APB word addressing, byte address is four times the index.
// Notes:   Timer period and hold values follow the time base map.

package icc_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int unsigned DATA_W  = 16;
	localparam int unsigned DEPTH   = 4;
	localparam int unsigned ADDR_W  = 12;
	localparam logic [2:0]  FULL_CNT = 3'h4;

	// ==========================================================
	// Register indices (byte address is index times four)
	// ==========================================================
	localparam logic [9:0] IDX_TA_COUNT  = 10'h106;
	localparam logic [9:0] IDX_TB_HOLD   = 10'h108;
	localparam logic [9:0] IDX_TB_COUNT  = 10'h10a;
	localparam logic [9:0] IDX_TA_PERIOD = 10'h10c;
	localparam logic [9:0] IDX_TB_PERIOD = 10'h10e;
	localparam logic [9:0] IDX_TA_CON    = 10'h110;
	localparam logic [9:0] IDX_TB_CON    = 10'h112;
	localparam logic [9:0] IDX_CAP_CTL   = 10'h140;
	localparam logic [9:0] IDX_CAP_BUF   = 10'h141;
	localparam logic [9:0] IDX_IFLAG     = 10'h142;
	localparam logic [9:0] IDX_IENABLE   = 10'h143;

	// ==========================================================
	// Field positions and masks
	// ==========================================================
	localparam int unsigned CTL_SIDL  = 13;
	localparam int unsigned CTL_TBSEL = 7;
	localparam int unsigned CTL_ICNT  = 5;
	localparam int unsigned CTL_OV    = 4;
	localparam int unsigned CTL_BNE   = 3;
	localparam int unsigned CTL_MODE  = 0;
	localparam int unsigned TMR_ON    = 15;
	localparam int unsigned TMR_SIDL  = 13;
	localparam logic [15:0] TA_CON_MASK = 16'ha07a;
	localparam logic [15:0] TB_CON_MASK = 16'ha072;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [15:0] PERIOD_RST = 16'hffff;
	localparam logic [15:0] CON_RST    = 16'h0000;

	// ==========================================================
	// Capture mode codes and prescaler terminal counts
	// ==========================================================
	localparam logic [2:0] MODE_OFF    = 3'h0;
	localparam logic [2:0] MODE_EVERY  = 3'h1;
	localparam logic [2:0] MODE_FALL   = 3'h2;
	localparam logic [2:0] MODE_RISE   = 3'h3;
	localparam logic [2:0] MODE_RISE4  = 3'h4;
	localparam logic [2:0] MODE_RISE16 = 3'h5;
	localparam logic [2:0] MODE_WAKE   = 3'h7;
	localparam logic [3:0] PRE4_LAST   = 4'h3;
	localparam logic [3:0] PRE16_LAST  = 4'hf;

	// Capture channel control fields.
	typedef struct packed {
		logic [2:0] mode;
		logic [1:0] icnt;
		logic       tbsel;
		logic       sidl;
	} icc_ctl_t;

	// Time base registers.
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] period;
		logic [15:0] con;
	} icc_tb_t;

	// APB answer.
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} icc_resp_t;

	// Whole module state.
	typedef struct packed {
		logic                          sync1;
		logic                          sync2;
		logic                          pin_prev;
		logic [DEPTH-1:0][DATA_W-1:0]  fifo;
		logic [2:0]                    cnt;
		logic                          ov;
		logic [3:0]                    presc;
		logic [1:0]                    evcnt;
		icc_ctl_t                      ctl;
		logic                          iflag;
		logic                          ienable;
		icc_tb_t                       ta;
		icc_tb_t                       tb;
		logic [15:0]                   tb_hold;
		icc_resp_t                     resp;
		logic                          irq;
		logic                          wake;
	} icc_state_t;

endpackage

/* File: icc_capture.sv */
// Purpose: Input capture channel with two time bases and an APB slave.
// Assumes: cap_pin is asynchronous; sleep and idle come from pclk logic.
// Notes:   Zero-wait APB; pready rises in the first access cycle.

`timescale 1ns/1ns

// Summary of operation
// - Three-bit mode picks falling, rising, 4th, 16th rising or every edge.
// - Turning the channel off clears the capture prescaler.
// - Any reset clears the capture prescaler.
// - Captures sit in a four-entry, 16-bit FIFO.
// - Not-empty goes high on first capture, low when all are read.
// - A read returns the oldest entry and shifts the rest forward.
// - Fifth event into a full FIFO is discarded and, outside every-edge mode, sets overflow.
// - After overflow nothing is captured until all entries are read.
// - Control bit 7 picks which time base is captured.
// - After reset the second time base is selected.
// - Every-edge mode flags each edge and ignores the event count.
// - Every-edge mode never raises overflow.
// - Mode 111 with enable wakes from sleep or idle, timer or not.
// - In sleep the channel is only an interrupt source, no prescale.
// - In idle full function needs selected timer on and stop bit 0.
// - Mode 111 in idle makes the pin a plain interrupt pin.
// - Interrupt follows a count of events set by control bits 6:5.
// - Own flag bit and enable bit gate the interrupt request.
module icc_capture
(
	// Clock and reset.
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// APB slave.
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [icc_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	// Capture pin and power state.
	input  wire logic                         cap_pin,
	input  wire logic                         cpu_sleep,
	input  wire logic                         cpu_idle,
	// Requests to the core.
	output logic                              capture_irq,
	output logic                              wake_request
);

	// ==========================================================
	// State
	// ==========================================================
	icc_pkg::icc_state_t s_q;
	icc_pkg::icc_state_t s_d;

	logic        rise;
	logic        fall;
	logic        edge_ev;
	logic        tmr_on;
	logic        low_pow;
	logic        wake_only;
	logic        halted;
	logic        cap_ev;
	logic        hit;
	logic        setup;
	logic        access;
	logic [9:0]  idx;
	logic [15:0] stamp;
	logic [31:0] rdata;
	logic [15:0] ctl_rd;

	// ==========================================================
	// Address decode and read mux
	// ==========================================================
	// Only the word index selects a register; low bits must be zero.
	assign idx    = paddr[icc_pkg::ADDR_W-1:2];
	assign setup  = psel & ~penable;
	assign access = psel & penable & s_q.resp.pready;

	// Control register read image with live FIFO status.
	always_comb
	begin
		ctl_rd = 16'h0000;
		ctl_rd[icc_pkg::CTL_SIDL] = s_q.ctl.sidl;
		ctl_rd[icc_pkg::CTL_TBSEL] = s_q.ctl.tbsel;
		ctl_rd[icc_pkg::CTL_ICNT +: 2] = s_q.ctl.icnt;
		ctl_rd[icc_pkg::CTL_OV] = s_q.ov;
		ctl_rd[icc_pkg::CTL_BNE] = (s_q.cnt != 3'h0);
		ctl_rd[icc_pkg::CTL_MODE +: 3] = s_q.ctl.mode;
	end

	// Unaligned or unknown addresses answer with an error.
	always_comb
	begin
		hit   = (paddr[1:0] == 2'h0);
		rdata = 32'h0000_0000;
		if (idx == icc_pkg::IDX_TA_COUNT)
			rdata[15:0] = s_q.ta.count;
		else if (idx == icc_pkg::IDX_TB_HOLD)
			rdata[15:0] = s_q.tb_hold;
		else if (idx == icc_pkg::IDX_TB_COUNT)
			rdata[15:0] = s_q.tb.count;
		else if (idx == icc_pkg::IDX_TA_PERIOD)
			rdata[15:0] = s_q.ta.period;
		else if (idx == icc_pkg::IDX_TB_PERIOD)
			rdata[15:0] = s_q.tb.period;
		else if (idx == icc_pkg::IDX_TA_CON)
			rdata[15:0] = s_q.ta.con;
		else if (idx == icc_pkg::IDX_TB_CON)
			rdata[15:0] = s_q.tb.con;
		else if (idx == icc_pkg::IDX_CAP_CTL)
			rdata[15:0] = ctl_rd;
		else if (idx == icc_pkg::IDX_CAP_BUF)
			rdata[15:0] = s_q.fifo[0];
		else if (idx == icc_pkg::IDX_IFLAG)
			rdata[0] = s_q.iflag;
		else if (idx == icc_pkg::IDX_IENABLE)
			rdata[0] = s_q.ienable;
		else
			hit = 1'b0;
	end

	// ==========================================================
	// Edge and event qualification
	// ==========================================================
	// The edge flop rests low after reset, like the idle pin, so no false
	// rise is seen when reset is released.
	assign rise = s_q.sync2 & ~s_q.pin_prev;
	assign fall = ~s_q.sync2 & s_q.pin_prev;

	// Time base select: one picks time base a, zero time base b.
	assign tmr_on = s_q.ctl.tbsel ? s_q.ta.con[icc_pkg::TMR_ON]
	                              : s_q.tb.con[icc_pkg::TMR_ON];
	assign stamp  = s_q.ctl.tbsel ? s_q.ta.count : s_q.tb.count;

	// In sleep only mode 111 is live; in sleep or idle it is a bare interrupt pin.
	// Wake-up works with the timer stopped, so no stamp is stored then.
	assign low_pow   = cpu_sleep | cpu_idle;
	assign wake_only = low_pow & (s_q.ctl.mode == icc_pkg::MODE_WAKE);
	assign halted    = cpu_sleep
	                 | (cpu_idle & (~tmr_on | s_q.ctl.sidl));

	// Mode decides which edges count; prescaled modes fire on the last.
	always_comb
	begin
		case (s_q.ctl.mode)
			icc_pkg::MODE_EVERY:  edge_ev = rise | fall;
			icc_pkg::MODE_FALL:   edge_ev = fall;
			icc_pkg::MODE_RISE:   edge_ev = rise;
			icc_pkg::MODE_WAKE:   edge_ev = rise;
			icc_pkg::MODE_RISE4:
				edge_ev = rise & (s_q.presc == icc_pkg::PRE4_LAST);
			icc_pkg::MODE_RISE16:
				edge_ev = rise & (s_q.presc == icc_pkg::PRE16_LAST);
			default:              edge_ev = 1'b0;
		endcase
	end

	assign cap_ev = edge_ev & ~halted & ~wake_only;

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		s_d = s_q;

		// Two-flop synchroniser, then a third flop for edge detect.
		s_d.sync1    = cap_pin;
		s_d.sync2    = s_q.sync1;
		s_d.pin_prev = s_q.sync2;

		// Switched-on time bases run unless asleep or stopped in idle.
		// Each counter wraps to zero on a match with its period.
		if (s_q.ta.con[icc_pkg::TMR_ON] & ~cpu_sleep
		    & ~(cpu_idle & s_q.ta.con[icc_pkg::TMR_SIDL]))
		begin
			if (s_q.ta.count == s_q.ta.period)
				s_d.ta.count = 16'h0000;
			else
				s_d.ta.count = s_q.ta.count + 16'h0001;
		end
		if (s_q.tb.con[icc_pkg::TMR_ON] & ~cpu_sleep
		    & ~(cpu_idle & s_q.tb.con[icc_pkg::TMR_SIDL]))
		begin
			if (s_q.tb.count == s_q.tb.period)
				s_d.tb.count = 16'h0000;
			else
				s_d.tb.count = s_q.tb.count + 16'h0001;
		end

		// APB: answer is prepared in setup, acted on at access.
		s_d.resp.pready  = 1'b0;
		s_d.resp.pslverr = 1'b0;
		if (setup)
		begin
			s_d.resp.pready  = 1'b1;
			s_d.resp.pslverr = ~hit;
			// A refused read returns zero rather than a register image.
			if (hit)
				s_d.resp.prdata = rdata;
			else
				s_d.resp.prdata = 32'h0000_0000;
		end
		if (access & hit & pwrite)
		begin
			if (idx == icc_pkg::IDX_TA_COUNT)
				s_d.ta.count = pwdata[15:0];
			else if (idx == icc_pkg::IDX_TB_HOLD)
				s_d.tb_hold = pwdata[15:0];
			else if (idx == icc_pkg::IDX_TB_COUNT)
				s_d.tb.count = pwdata[15:0];
			else if (idx == icc_pkg::IDX_TA_PERIOD)
				s_d.ta.period = pwdata[15:0];
			else if (idx == icc_pkg::IDX_TB_PERIOD)
				s_d.tb.period = pwdata[15:0];
			else if (idx == icc_pkg::IDX_TA_CON)
				s_d.ta.con = pwdata[15:0] & icc_pkg::TA_CON_MASK;
			else if (idx == icc_pkg::IDX_TB_CON)
				s_d.tb.con = pwdata[15:0] & icc_pkg::TB_CON_MASK;
			else if (idx == icc_pkg::IDX_CAP_CTL)
			begin
				s_d.ctl.sidl  = pwdata[icc_pkg::CTL_SIDL];
				s_d.ctl.tbsel = pwdata[icc_pkg::CTL_TBSEL];
				s_d.ctl.icnt  = pwdata[icc_pkg::CTL_ICNT +: 2];
				s_d.ctl.mode  = pwdata[icc_pkg::CTL_MODE +: 3];
			end
			// A software clear loses to a capture in the same cycle, as the
			// capture logic below writes the flag after this point.
			else if (idx == icc_pkg::IDX_IFLAG)
				s_d.iflag = pwdata[0];
			else if (idx == icc_pkg::IDX_IENABLE)
				s_d.ienable = pwdata[0];
		end

		// A buffer read pops the oldest word; an empty read pops nothing.
		// A refused (unaligned) read must not lose a stored stamp either.
		if (access & hit & ~pwrite & (idx == icc_pkg::IDX_CAP_BUF)
		    & (s_q.cnt != 3'h0))
		begin
			for (int i = 0; i < icc_pkg::DEPTH - 1; i++)
				s_d.fifo[i] = s_q.fifo[i+1];
			s_d.fifo[icc_pkg::DEPTH-1] = 16'h0000;
			s_d.cnt = s_q.cnt - 3'h1;
			if (s_q.cnt == 3'h1)
				s_d.ov = 1'b0;
		end

		// Prescaler counts qualifying rising edges while awake, or in idle with the selected timer on and stop bit 0.
		if (rise & ~halted & ~wake_only
		    & ((s_q.ctl.mode == icc_pkg::MODE_RISE4)
		    | (s_q.ctl.mode == icc_pkg::MODE_RISE16)))
		begin
			if (edge_ev)
				s_d.presc = 4'h0;
			else
				s_d.presc = s_q.presc + 4'h1;
		end

		// Store the time stamp; a blocked or full FIFO drops the event.
		// The push uses the post-pop count, so a read and a capture in one
		// cycle keep the order and never report a false overflow.
		if (cap_ev)
		begin
			if (s_q.ov)
			begin
				s_d.ov = 1'b1;
			end
			else if (s_d.cnt == icc_pkg::FULL_CNT)
			begin
				if (s_q.ctl.mode != icc_pkg::MODE_EVERY)
					s_d.ov = 1'b1;
			end
			else
			begin
				s_d.fifo[s_d.cnt[1:0]] = stamp;
				s_d.cnt = s_d.cnt + 3'h1;
				if (s_q.ctl.mode != icc_pkg::MODE_EVERY)
				begin
					if (s_q.evcnt == s_q.ctl.icnt)
					begin
						s_d.evcnt = 2'h0;
						s_d.iflag = 1'b1;
					end
					else
						s_d.evcnt = s_q.evcnt + 2'h1;
				end
			end
			if (s_q.ctl.mode == icc_pkg::MODE_EVERY)
				s_d.iflag = 1'b1;
		end

		// Mode 111 while asleep or idle flags each rising edge directly.
		if (wake_only & rise)
			s_d.iflag = 1'b1;

		// Switching the channel off restarts event counting.
		// The FIFO keeps its words so software can still drain old stamps.
		if (s_d.ctl.mode == icc_pkg::MODE_OFF)
		begin
			s_d.presc = 4'h0;
			s_d.evcnt = 2'h0;
		end

		// Flag gated by its enable; any flagged event wakes the core.
		s_d.irq  = s_d.iflag & s_d.ienable;
		s_d.wake = s_d.iflag & s_d.ienable & low_pow;
	end

	// ==========================================================
	// State register
	// ==========================================================
	// Reset clears every field, then loads the non-zero reset values.
	// The select is spelled out because zero means time base b.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q           <= '0;
			s_q.ctl.tbsel <= 1'b0;
			s_q.ta.period <= icc_pkg::PERIOD_RST;
			s_q.tb.period <= icc_pkg::PERIOD_RST;
			s_q.ta.con    <= icc_pkg::CON_RST;
			s_q.tb.con    <= icc_pkg::CON_RST;
		end
		else
			s_q <= s_d;
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	// ==========================================================
	assign prdata       = s_q.resp.prdata;
	assign pready       = s_q.resp.pready;
	assign pslverr      = s_q.resp.pslverr;
	assign capture_irq  = s_q.irq;
	assign wake_request = s_q.wake;

endmodule

/* File: icc_edge_src.sv */
// Purpose: Edge source standing in for the signal on the capture pin.
// Assumes: Levels change by non-blocking assignment after a pclk edge.
// Notes:   Each level is held long enough to pass the synchroniser.
`timescale 1ns/1ns
module icc_edge_src
(
	// Clock.
	input  wire logic pclk,
	// Capture pin.
	output logic      cap_pin
);
	// The pin rests low, so the first change of a pulse is a rise.
	initial cap_pin = 1'b0;

	// Full pulses, each level held for h cycles; one edge per level.
	task automatic pulses(input int n, input int h);
		for (int i = 0; i < 2 * n; i++)
		begin
			@(posedge pclk);
			cap_pin <= ~cap_pin;
			repeat (h - 1) @(posedge pclk);
		end
	endtask
endmodule

/* File: icc_capture_props.sv */
// Purpose: Port assertions for the input capture channel.
// Assumes: Zero-wait APB slave; irq and wake are registered levels.
// Notes:   Pin changes reach the flags some three edges later.
`timescale 1ns/1ns
module icc_capture_props
(
	// Clock and reset.
	input wire logic                       pclk,
	input wire logic                       presetn,
	// APB.
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [icc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	// Pin, power state and requests.
	input wire logic                       cap_pin,
	input wire logic                       cpu_sleep,
	input wire logic                       cpu_idle,
	input wire logic                       capture_irq,
	input wire logic                       wake_request
);
	// ====================
	// Checks
	// ====================
	// One clock domain; every check pauses while reset is low.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_after_setup:
		assert property (pready == $past(psel && !penable))
		else $error("pready not one cycle after setup");
	a_err_with_ready:
		assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_unaligned:
		assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("unaligned access not refused");
	a_err_read_zero:
		assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_upper_zero:
		assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	// Wake follows the request only while the core is in a low-power state.
	a_wake_low_power:
		assert property (capture_irq && $past(cpu_sleep || cpu_idle)
			|-> wake_request)
		else $error("wake missing in low power");
	a_wake_needs_irq:
		assert property (wake_request
			|-> capture_irq && $past(cpu_sleep || cpu_idle))
		else $error("wake without cause");
	// A rising request needs a register write or a recent pin change.
	a_irq_has_cause:
		assert property ($rose(capture_irq) |-> $past(psel && pwrite)
			|| $past(cap_pin, 3) != $past(cap_pin, 7))
		else $error("interrupt without cause");
endmodule

bind icc_capture icc_capture_props u_props
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .cap_pin(cap_pin),
	.cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
	.capture_irq(capture_irq), .wake_request(wake_request)
);

/* File: tb_top.sv */
// Purpose: Self-checking bench for the input capture channel.
// Assumes: Time bases stay stopped unless a scenario starts one.
// Notes:   Stopped counts make every captured stamp predictable.
`timescale 1ns/1ns
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        cap_pin, cpu_sleep, cpu_idle, capture_irq, wake_request;
	logic [11:0] paddr;
	logic [1:0]  lo;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] c;
	logic [15:0] v[6];
	int          n_mismatch, compares, k;

	icc_capture dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cap_pin(cap_pin), .cpu_sleep(cpu_sleep),
		.cpu_idle(cpu_idle), .capture_irq(capture_irq),
		.wake_request(wake_request));
	icc_edge_src src (.pclk(pclk), .cap_pin(cap_pin));

	// ====================
	// Clock and helpers
	// ====================
	// A 4 ns period gives the 250 MHz bus clock.
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// One transfer after an idle cycle, so psel never changes twice at once.
	task automatic apb(input logic w, input logic [9:0] i,
		input logic [15:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= {i, lo};
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		chk({31'h0, pslverr}, {31'h0, i == 10'h3ff || lo != 2'h0});
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			n_mismatch++;
			$display("unexpected at %0t: no pready", $time);
			complete_run();
		end
	endtask

	task automatic rctl(input logic [31:0] e);
		apb(1'b0, icc_pkg::IDX_CAP_CTL, 16'h0);
		chk(rdat, e);
	endtask

	task automatic rbuf(input logic [15:0] e);
		apb(1'b0, icc_pkg::IDX_CAP_BUF, 16'h0);
		chk(rdat, {16'h0, e});
	endtask

	// Pulses with a random hold, then time for the synchroniser.
	task automatic edges(input int n);
		src.pulses(n, 6 + int'($urandom % 3));
		repeat (5) @(posedge pclk);
	endtask

	function automatic int caps(input logic [2:0] m, input int n);
		if (m == icc_pkg::MODE_RISE4)
			return n / 4;
		if (m == icc_pkg::MODE_RISE16)
			return n / 16;
		return m == icc_pkg::MODE_EVERY ? 2 * n : n;
	endfunction

	// Control readback carrying the buffer flags after n captures.
	function automatic logic [31:0] ctlv(input logic [15:0] x, input int n);
		ctlv = {16'h0, x};
		ctlv[icc_pkg::CTL_BNE] = n > 0;
		ctlv[icc_pkg::CTL_OV] = n > 4 && x[2:0] != icc_pkg::MODE_EVERY;
	endfunction

	task automatic complete_run;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ====================
	// Scenarios
	// ====================
	// Reset values, interrupts, modes, overflow and power states in turn.
	initial
	begin
		{presetn, psel, penable, pwrite, cpu_sleep, cpu_idle} = '0;
		paddr = '0;
		lo = '0;
		pwdata = '0;
		{n_mismatch, compares} = '0;
		k = $urandom(71);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, icc_pkg::IDX_TB_PERIOD, 16'h0);
		chk(rdat, 32'hffff);
		rctl(32'h0);
		apb(1'b0, 10'h3ff, 16'h0);
		chk(rdat, 32'h0);
		// Unaligned accesses are refused: no write, zero read data.
		lo = 2'h2;
		apb(1'b1, icc_pkg::IDX_TB_PERIOD, 16'h1234);
		apb(1'b0, icc_pkg::IDX_TB_PERIOD, 16'h0);
		chk(rdat, 32'h0);
		lo = 2'h0;
		apb(1'b0, icc_pkg::IDX_TB_PERIOD, 16'h0);
		chk(rdat, 32'hffff);
		apb(1'b1, icc_pkg::IDX_IENABLE, 16'h1);
		apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0023);
		edges(1);
		chk(capture_irq, 1'b0);
		edges(1);
		chk(capture_irq, 1'b1);
		apb(1'b1, icc_pkg::IDX_IFLAG, 16'h0);
		@(posedge pclk);
		chk(capture_irq, 1'b0);
		apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0061);
		edges(1);
		chk(capture_irq, 1'b1);
		// Reset and switch-off both restart the divide-by-four count.
		apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0004);
		edges(3);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		// Reset cleared the enable too; later checks need it set again.
		apb(1'b1, icc_pkg::IDX_IENABLE, 16'h1);
		apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0004);
		edges(1);
		rctl(32'h4);
		edges(2);
		apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0000);
		apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0004);
		edges(1);
		rctl(32'h4);
		edges(3);
		rctl(ctlv(16'h4, 1));
		rbuf(16'h0);
		// Modes 1 to 5, alternating time bases, sixteen pulses each.
		for (int m = 1; m < 6; m++)
		begin
			c = {8'h0, m[0], 4'h0, 3'(m)};
			v[0] = 16'($urandom);
			apb(1'b1, icc_pkg::IDX_TA_COUNT, v[0]);
			apb(1'b1, icc_pkg::IDX_TB_COUNT, ~v[0]);
			apb(1'b1, icc_pkg::IDX_CAP_CTL, c);
			edges(16);
			k = caps(c[2:0], 16);
			rctl(ctlv(c, k));
			repeat (k > 4 ? 4 : k)
				rbuf(m[0] ? v[0] : ~v[0]);
			rctl(ctlv(c, 0));
			apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0);
		end
		// The fifth stamp is lost and later ones wait for a full drain.
		apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0003);
		for (int j = 0; j < 6; j++)
		begin
			v[j] = 16'($urandom);
			apb(1'b1, icc_pkg::IDX_TB_COUNT, v[j]);
			edges(1);
			if (j == 4)
				rctl(ctlv(16'h3, 5));
			if (j == 4)
				rbuf(v[0]);
		end
		for (int j = 1; j < 4; j++)
			rbuf(v[j]);
		rctl(32'h3);
		// Wake-up only mode in sleep, then in idle.
		for (int j = 0; j < 2; j++)
		begin
			apb(1'b1, icc_pkg::IDX_IFLAG, 16'h0);
			apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0007);
			cpu_sleep <= j == 0;
			cpu_idle  <= j == 1;
			edges(1);
			chk(wake_request, 1'b1);
			cpu_sleep <= 1'b0;
			cpu_idle  <= 1'b0;
			rctl(32'h7);
		end
		// Sleep ignores the prescaler; idle needs the chosen timer running.
		apb(1'b1, icc_pkg::IDX_CAP_CTL, 16'h0004);
		cpu_sleep <= 1'b1;
		edges(4);
		cpu_sleep <= 1'b0;
		rctl(32'h4);
		cpu_idle <= 1'b1;
		edges(4);
		rctl(32'h4);
		apb(1'b1, icc_pkg::IDX_TB_CON, 16'h8000);
		edges(4);
		rctl(ctlv(16'h4, 1));
		complete_run();
	end
endmodule
